// [rtl/msd_pkg.sv]
// Constants and types shared by the memory space decoder files
package msd_pkg;

  // --------------------------------------------------------------
  // Memory sizes and space boundaries
  // --------------------------------------------------------------
  localparam int unsigned MSD_IRAM_BYTES = 256;
  localparam int unsigned MSD_EXTENDED_RAM_BYTES = 2048;
  localparam logic [15:0] MSD_EXTENDED_RAM_LIMIT = 16'h0800;
  localparam logic [15:0] MSD_CODE_LIMIT = 16'hF800;
  localparam logic [7:0] MSD_BIT_BYTE_BASE = 8'h20;
  localparam logic [7:0] MSD_READ_FILL = 8'hFF;

  // --------------------------------------------------------------
  // Power control register
  // --------------------------------------------------------------
  localparam logic [7:0] MSD_PWR_CTRL_ADDR = 8'h87;
  localparam logic [7:0] MSD_PWR_CTRL_RESET = 8'h00;

  // --------------------------------------------------------------
  // Cycle and byte costs per operation
  // --------------------------------------------------------------
  localparam logic [2:0] MSD_CYC_REG = 3'h1;
  localparam logic [2:0] MSD_CYC_IMM = 3'h2;
  localparam logic [2:0] MSD_CYC_DIR = 3'h2;
  localparam logic [2:0] MSD_CYC_IND = 3'h2;
  localparam logic [2:0] MSD_CYC_RI_IMM = 3'h2;
  localparam logic [2:0] MSD_CYC_DATA_POINTER_IMM = 3'h3;
  localparam logic [2:0] MSD_CYC_XMOVE = 3'h4;
  localparam logic [2:0] MSD_CYC_CMOVE = 3'h4;
  localparam logic [2:0] MSD_CYC_BIT = 3'h2;
  localparam logic [1:0] MSD_BYT_ONE = 2'h1;
  localparam logic [1:0] MSD_BYT_TWO = 2'h2;
  localparam logic [1:0] MSD_BYT_THREE = 2'h3;

  // Operations issued by the execution unit
  typedef enum logic [3:0] {
    MSD_OP_REG,
    MSD_OP_IMM,
    MSD_OP_DIR,
    MSD_OP_IND,
    MSD_OP_RI_IMM,
    MSD_OP_DATA_POINTER_IMM,
    MSD_OP_XMOVE_DATA_POINTER,
    MSD_OP_XMOVE_RI,
    MSD_OP_CMOVE,
    MSD_OP_BIT
  } msd_op_t;

  // Space that served an access
  typedef enum logic [2:0] {
    MSD_SP_NONE,
    MSD_SP_IRAM,
    MSD_SP_SFR,
    MSD_SP_EXTENDED_RAM,
    MSD_SP_CODE
  } msd_space_t;

endpackage : msd_pkg

// [rtl/msd_ram.sv]
// Flip-flop byte array with one write port and two read ports
`timescale 1ns/1ns
module msd_ram #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 256,
  localparam int unsigned AW = $clog2(DEPTH)
) (
  input wire logic clk_sys,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr_a,
  output logic [WIDTH-1:0] rd_data_a,
  input wire logic [AW-1:0] rd_addr_b,
  output logic [WIDTH-1:0] rd_data_b
);

  // --------------------------------------------------------------
  // Parameter check
  // --------------------------------------------------------------
  if (DEPTH < 2 || WIDTH < 1 || (1 << AW) != DEPTH)
  begin : g_bad_param
    $error("msd_ram needs a power of two depth of at least two");
  end

  // --------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------
  logic [WIDTH-1:0] mem_q [DEPTH];

  // Write port, contents are data and carry no reset
  always_ff @(posedge clk_sys)
  begin
    if (wr_en)
    begin
      mem_q[wr_addr] <= wr_data;
    end
  end

  // Read ports see the stored value at once
  assign rd_data_a = mem_q[rd_addr_a];
  assign rd_data_b = mem_q[rd_addr_b];

endmodule : msd_ram

// [rtl/msd_cost.sv]
// Cycle and program byte cost of each operation
`timescale 1ns/1ns
module msd_cost
  import msd_pkg::*;
(
  input msd_pkg::msd_op_t op,
  output logic [2:0] cycles,
  output logic [1:0] bytes
);

  // Cost lookup
  always_comb
  begin
    unique case (op)
      MSD_OP_REG:
      begin
        cycles = MSD_CYC_REG;
        bytes = MSD_BYT_ONE;
      end
      MSD_OP_IMM:
      begin
        cycles = MSD_CYC_IMM;
        bytes = MSD_BYT_TWO;
      end
      MSD_OP_DIR:
      begin
        cycles = MSD_CYC_DIR;
        bytes = MSD_BYT_TWO;
      end
      MSD_OP_IND:
      begin
        cycles = MSD_CYC_IND;
        bytes = MSD_BYT_ONE;
      end
      MSD_OP_RI_IMM:
      begin
        cycles = MSD_CYC_RI_IMM;
        bytes = MSD_BYT_TWO;
      end
      MSD_OP_DATA_POINTER_IMM:
      begin
        cycles = MSD_CYC_DATA_POINTER_IMM;
        bytes = MSD_BYT_THREE;
      end
      MSD_OP_XMOVE_DATA_POINTER, MSD_OP_XMOVE_RI:
      begin
        cycles = MSD_CYC_XMOVE;
        bytes = MSD_BYT_ONE;
      end
      MSD_OP_CMOVE:
      begin
        cycles = MSD_CYC_CMOVE;
        bytes = MSD_BYT_ONE;
      end
      MSD_OP_BIT:
      begin
        cycles = MSD_CYC_BIT;
        bytes = MSD_BYT_TWO;
      end
      // Unused operation codes cost as a register move, no latch
      default:
      begin
        cycles = MSD_CYC_REG;
        bytes = MSD_BYT_ONE;
      end
    endcase
  end

endmodule : msd_cost

// [rtl/msd_decoder.sv]
// Operand memory space decoder with internal and extended RAM
// Operation
// RQ1 - Direct access to 0x80..0xFF selects the special function space
// RQ2 - Indirect access to 0x80..0xFF selects upper RAM, never a register
// RQ3 - RAM 0x00..0x7F reached by direct and indirect at one location
// RQ4 - 256 RAM bytes; upper half overlaps registers, mode picks which
// RQ5 - Bit addresses 0x00..0x7F map to RAM bytes 0x20..0x2F ascending
// RQ6 - Extended accesses hit a 2 kB array; no external RAM port
// RQ7 - Code reads come from 62 kB on-chip flash only
// RQ8 - Extended direct mode uses the full 16-bit data pointer
// RQ9 - Pointer load plus indirect read takes four cycles, three bytes
// RQ10 - Pointer load plus extended read takes seven cycles, four bytes
// RQ11 - Immediate move to accumulator costs two bytes and two cycles
// RQ12 - Register to accumulator move takes one cycle, one byte
// RQ13 - Power control at 0x87, byte access only, not bit addressed
// RQ14 - Working register banks sit in lowest RAM, chosen by bank bits
`timescale 1ns/1ns
module msd_decoder
  import msd_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic req_valid,
  output logic req_ready,
  input msd_pkg::msd_op_t req_op,
  input wire logic req_wr,
  input wire logic [7:0] req_addr,
  input wire logic [2:0] req_reg,
  input wire logic [15:0] req_data,
  input wire logic [7:0] acc_in,
  input wire logic [1:0] bank_sel,
  output logic done_q,
  output logic [7:0] rd_data_q,
  output logic bit_q,
  output msd_pkg::msd_space_t space_q,
  output logic [2:0] cycles_q,
  output logic [1:0] bytes_q,
  output logic range_err_q,
  output logic [15:0] data_pointer_q,
  output logic [7:0] power_control_q,
  output logic sfr_en,
  output logic sfr_wr,
  output logic [7:0] sfr_addr,
  output logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  output logic code_en,
  output logic [15:0] code_addr,
  input wire logic [7:0] code_rdata
);

  // --------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------
  typedef enum logic {MSD_IDLE, MSD_BUSY} msd_state_t;

  msd_state_t state_q, state_d;
  msd_op_t op_q, op_d;
  logic wr_q, wr_d;
  logic [7:0] addr_q, addr_d;
  logic [2:0] reg_q, reg_d;
  logic [15:0] data_q, data_d;
  logic [7:0] acc_q, acc_d;
  logic [1:0] bank_q, bank_d;
  logic [2:0] cnt_q, cnt_d;
  logic [2:0] req_cycles, cycles_d;
  logic [1:0] req_bytes, bytes_d;
  logic fire;
  logic done_d, bit_d, err_d;
  logic [7:0] rd_data_d, pwr_d, iram_a, iram_b, ra_addr, rb_addr;
  logic [15:0] data_pointer_d, xaddr;
  logic [10:0] extended_ram_addr;
  logic [7:0] extended_ram_rd, extended_ram_unused, bit_byte;
  logic iram_we, extended_ram_we;
  logic [7:0] iram_wa, iram_wd;
  msd_space_t space_d;

  // Working register location for a bank and register number
  function automatic logic [7:0] msd_reg_addr(input logic [1:0] bank,
                                              input logic [2:0] num);
    msd_reg_addr = {3'h0, bank, num};
  endfunction : msd_reg_addr

  // --------------------------------------------------------------
  // Sub blocks
  // --------------------------------------------------------------
  msd_cost u_cost (
    .op(req_op),
    .cycles(req_cycles),
    .bytes(req_bytes)
  );

  // General purpose RAM, all 256 bytes
  msd_ram #(.WIDTH(8), .DEPTH(MSD_IRAM_BYTES)) u_iram ( // RQ4
    .clk_sys(clk_sys),
    .wr_en(iram_we),
    .wr_addr(iram_wa),
    .wr_data(iram_wd),
    .rd_addr_a(ra_addr),
    .rd_data_a(iram_a),
    .rd_addr_b(rb_addr),
    .rd_data_b(iram_b)
  );

  // Extended RAM, the only extended space
  msd_ram #(.WIDTH(8), .DEPTH(MSD_EXTENDED_RAM_BYTES)) u_extended_ram ( // RQ6
    .clk_sys(clk_sys),
    .wr_en(extended_ram_we),
    .wr_addr(extended_ram_addr),
    .wr_data(acc_q),
    .rd_addr_a(extended_ram_addr),
    .rd_data_a(extended_ram_rd),
    .rd_addr_b(11'h000),
    .rd_data_b(extended_ram_unused)
  );

  // --------------------------------------------------------------
  // Request control
  // --------------------------------------------------------------
  assign req_ready = (state_q == MSD_IDLE);
  assign fire = (state_q == MSD_BUSY) && (cnt_q == 3'h0);

  // Next request latch and cycle counter
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    op_d = op_q;
    wr_d = wr_q;
    addr_d = addr_q;
    reg_d = reg_q;
    data_d = data_q;
    acc_d = acc_q;
    bank_d = bank_q;
    unique case (state_q)
      MSD_IDLE:
      begin
        if (req_valid)
        begin
          state_d = MSD_BUSY;
          cnt_d = req_cycles - 3'h1; // RQ9 RQ10 RQ11 RQ12
          op_d = req_op;
          wr_d = req_wr;
          addr_d = req_addr;
          reg_d = req_reg;
          data_d = req_data;
          acc_d = acc_in;
          bank_d = bank_sel;
        end
      end
      MSD_BUSY:
      begin
        if (fire)
        begin
          state_d = MSD_IDLE;
        end
        else
        begin
          cnt_d = cnt_q - 3'h1;
        end
      end
    endcase
  end

  // Request registers
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state_q <= MSD_IDLE;
      cnt_q <= 3'h0;
      op_q <= MSD_OP_REG;
      wr_q <= 1'b0;
      addr_q <= 8'h00;
      reg_q <= 3'h0;
      data_q <= 16'h0000;
      acc_q <= 8'h00;
      bank_q <= 2'h0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      op_q <= op_d;
      wr_q <= wr_d;
      addr_q <= addr_d;
      reg_q <= reg_d;
      data_q <= data_d;
      acc_q <= acc_d;
      bank_q <= bank_d;
    end
  end

  // --------------------------------------------------------------
  // Space decode
  // --------------------------------------------------------------
  assign xaddr = (op_q == MSD_OP_XMOVE_DATA_POINTER) ? data_pointer_q // RQ8
                                             : {8'h00, iram_a};
  assign extended_ram_addr = xaddr[10:0];
  assign bit_byte = MSD_BIT_BYTE_BASE + {4'h0, addr_q[6:3]}; // RQ5

  // Address routing and results of the access in its last cycle
  always_comb
  begin
    ra_addr = (op_q == MSD_OP_REG) ? msd_reg_addr(bank_q, reg_q) // RQ14
                                   : msd_reg_addr(bank_q, {2'h0, reg_q[0]});
    rb_addr = addr_q;
    space_d = MSD_SP_NONE;
    rd_data_d = rd_data_q;
    bit_d = bit_q;
    err_d = 1'b0;
    pwr_d = power_control_q;
    data_pointer_d = data_pointer_q;
    iram_we = 1'b0;
    iram_wa = rb_addr;
    iram_wd = acc_q;
    extended_ram_we = 1'b0;
    sfr_en = 1'b0;
    sfr_wr = 1'b0;
    sfr_addr = addr_q;
    sfr_wdata = acc_q;
    code_en = 1'b0;
    code_addr = data_pointer_q + {8'h00, acc_q};
    unique case (op_q)
      MSD_OP_REG:
      begin
        space_d = MSD_SP_IRAM;
        rd_data_d = iram_a; // RQ12
      end
      MSD_OP_IMM:
      begin
        rd_data_d = data_q[7:0]; // RQ11
      end
      MSD_OP_DIR:
      begin
        if (addr_q == MSD_PWR_CTRL_ADDR)
        begin
          space_d = MSD_SP_SFR;
          rd_data_d = wr_q ? rd_data_q : power_control_q; // RQ13
          pwr_d = wr_q ? acc_q : power_control_q;
        end
        else if (addr_q[7])
        begin
          space_d = MSD_SP_SFR; // RQ1
          sfr_en = fire;
          sfr_wr = fire && wr_q;
          rd_data_d = wr_q ? rd_data_q : sfr_rdata;
        end
        else
        begin
          space_d = MSD_SP_IRAM; // RQ3
          iram_we = fire && wr_q;
          rd_data_d = wr_q ? rd_data_q : iram_b;
        end
      end
      MSD_OP_IND:
      begin
        rb_addr = iram_a; // RQ2 RQ3
        iram_wa = iram_a;
        space_d = MSD_SP_IRAM;
        iram_we = fire && wr_q;
        rd_data_d = wr_q ? rd_data_q : iram_b;
      end
      MSD_OP_RI_IMM:
      begin
        space_d = MSD_SP_IRAM;
        iram_wa = ra_addr;
        iram_wd = data_q[7:0];
        iram_we = fire;
      end
      MSD_OP_DATA_POINTER_IMM:
      begin
        data_pointer_d = data_q;
      end
      MSD_OP_XMOVE_DATA_POINTER, MSD_OP_XMOVE_RI:
      begin
        if (xaddr < MSD_EXTENDED_RAM_LIMIT)
        begin
          space_d = MSD_SP_EXTENDED_RAM; // RQ6
          extended_ram_we = fire && wr_q;
          rd_data_d = wr_q ? rd_data_q : extended_ram_rd;
        end
        else
        begin
          err_d = 1'b1;
          rd_data_d = MSD_READ_FILL;
        end
      end
      MSD_OP_CMOVE:
      begin
        if (code_addr < MSD_CODE_LIMIT)
        begin
          space_d = MSD_SP_CODE; // RQ7
          code_en = fire;
          rd_data_d = code_rdata;
        end
        else
        begin
          err_d = 1'b1;
          rd_data_d = MSD_READ_FILL;
        end
      end
      MSD_OP_BIT:
      begin
        if (addr_q[7])
        begin
          // Whole byte is read, one bit replaced, byte written back
          space_d = MSD_SP_SFR;
          sfr_addr = {addr_q[7:3], 3'h0}; // RQ13
          sfr_en = fire;
          sfr_wr = fire && wr_q;
          sfr_wdata = sfr_rdata;
          sfr_wdata[addr_q[2:0]] = data_q[0];
          bit_d = sfr_rdata[addr_q[2:0]];
        end
        else
        begin
          space_d = MSD_SP_IRAM;
          rb_addr = bit_byte; // RQ5
          iram_wa = bit_byte;
          iram_wd = iram_b;
          iram_wd[addr_q[2:0]] = data_q[0];
          iram_we = fire && wr_q;
          bit_d = iram_b[addr_q[2:0]];
        end
      end
    endcase
  end

  // --------------------------------------------------------------
  // Result registers
  // --------------------------------------------------------------
  // Completion pulse and costs of the request being accepted
  assign done_d = fire;
  assign cycles_d = (req_valid && req_ready) ? req_cycles : cycles_q;
  assign bytes_d = (req_valid && req_ready) ? req_bytes : bytes_q;

  // Results are captured in the access cycle, costs at acceptance
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      done_q <= 1'b0;
      rd_data_q <= 8'h00;
      bit_q <= 1'b0;
      space_q <= MSD_SP_NONE;
      range_err_q <= 1'b0;
      power_control_q <= MSD_PWR_CTRL_RESET;
      data_pointer_q <= 16'h0000;
      cycles_q <= 3'h0;
      bytes_q <= 2'h0;
    end
    else
    begin
      done_q <= done_d;
      cycles_q <= cycles_d;
      bytes_q <= bytes_d;
      if (fire)
      begin
        rd_data_q <= rd_data_d;
        bit_q <= bit_d;
        space_q <= space_d;
        range_err_q <= err_d;
        power_control_q <= pwr_d;
        data_pointer_q <= data_pointer_d;
      end
    end
  end

  // --------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  chk_dir_sfr_sel: assert property (fire && op_q == MSD_OP_DIR // RQ1
    && addr_q[7] && addr_q != MSD_PWR_CTRL_ADDR |-> sfr_en && !iram_we)
    else $error("direct upper access did not go to registers");
  chk_ind_upper_ram: assert property (fire && op_q == MSD_OP_IND // RQ2
    |-> !sfr_en && space_d == MSD_SP_IRAM && rb_addr == iram_a)
    else $error("indirect access left general RAM");
  chk_low_same_loc: assert property (fire && op_q == MSD_OP_DIR // RQ3
    && !addr_q[7] |-> rb_addr == addr_q && space_d == MSD_SP_IRAM)
    else $error("direct low access used wrong RAM location");
  chk_overlap_mode: assert property (sfr_en |-> !iram_we // RQ4
    && op_q inside {MSD_OP_DIR, MSD_OP_BIT})
    else $error("register space used by a non direct mode");
  chk_bit_map: assert property (fire && op_q == MSD_OP_BIT // RQ5
    && !addr_q[7] |-> rb_addr == 8'h20 + {4'h0, addr_q[6:3]})
    else $error("bit address mapped to wrong byte");
  chk_extended_ram_range: assert property (extended_ram_we |-> xaddr < 16'h0800) // RQ6
    else $error("extended write beyond 2 kB");
  chk_code_range: assert property (code_en |-> code_addr < 16'hF800) // RQ7
    else $error("code read beyond flash");
  chk_data_pointer_full: assert property (fire && op_q == MSD_OP_XMOVE_DATA_POINTER // RQ8
    |-> xaddr == data_pointer_q)
    else $error("extended direct address not the data pointer");
  chk_ind_cost: assert property (req_valid && req_ready // RQ9
    && req_op inside {MSD_OP_IND, MSD_OP_RI_IMM}
    |=> !done_q ##1 !done_q ##1 done_q)
    else $error("pointer load or indirect read not two cycles");
  chk_xmove_cost: assert property (req_valid && req_ready // RQ10
    && req_op == MSD_OP_XMOVE_DATA_POINTER |=> !done_q[*4] ##1 done_q)
    else $error("extended read not four cycles");
  chk_data_pointer_cost: assert property (req_valid && req_ready // RQ10
    && req_op == MSD_OP_DATA_POINTER_IMM |=> !done_q[*3] ##1 done_q
    && bytes_q == 2'h3)
    else $error("pointer load not three cycles");
  chk_imm_cost: assert property (req_valid && req_ready // RQ11
    && req_op == MSD_OP_IMM |=> !done_q[*2] ##1 done_q
    && bytes_q == 2'h2 && rd_data_q == $past(req_data[7:0], 3))
    else $error("immediate move cost or value wrong");
  chk_reg_cost: assert property (req_valid && req_ready // RQ12
    && req_op == MSD_OP_REG |=> !done_q ##1 done_q && cycles_q == 3'h1
    && bytes_q == 2'h1)
    else $error("register move not one cycle");
  chk_pwr_bit_free: assert property (fire && op_q == MSD_OP_BIT // RQ13
    |=> $stable(power_control_q))
    else $error("bit access touched power control");
  chk_bank_reg: assert property (fire && op_q == MSD_OP_REG // RQ14
    |-> ra_addr == {3'h0, bank_q, reg_q})
    else $error("working register outside its bank");

  cov_sfr_read: cover property (fire && space_d == MSD_SP_SFR);
  cov_extended_ram_write: cover property (extended_ram_we);
  cov_code_read: cover property (code_en);
  cov_bit_write: cover property (fire && op_q == MSD_OP_BIT && wr_q);

endmodule : msd_decoder

// [verification/msd_far_model.sv]
// Register space and flash responder on the decoder's far side
`timescale 1ns/1ns
module msd_far_model
(
  input wire logic clk_sys,
  input wire logic sfr_en,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic code_en,
  input wire logic [15:0] code_addr,
  output logic [7:0] code_rdata
);
  logic [7:0] regs_q [0:127];
  logic [7:0] sfr_last_q = 8'h00;
  logic [7:0] code_last_q = 8'h00;
  logic [7:0] code_byte;

  // Flash content is a fixed pattern of the address
  assign code_byte = code_addr[7:0] ^ code_addr[15:8] ^ 8'h5C;

  // Same-cycle answers; deselected lines show the inverse of the last value
  assign sfr_rdata = sfr_en ? regs_q[sfr_addr[6:0]] : ~sfr_last_q;
  assign code_rdata = code_en ? code_byte : ~code_last_q;

  // Register store and memory of the last value driven
  always @(posedge clk_sys)
  begin
    if (sfr_en)
    begin
      sfr_last_q <= regs_q[sfr_addr[6:0]];
      if (sfr_wr)
        regs_q[sfr_addr[6:0]] <= sfr_wdata;
    end
    if (code_en)
      code_last_q <= code_byte;
  end
endmodule : msd_far_model

// [verification/msd_decoder_bench.sv]
// Self-checking bench for the operand memory space decoder
`timescale 1ns/1ns
module msd_decoder_bench;
  import msd_pkg::*;

  // ----------------------------------------------------------
  // Signals and instances
  // ----------------------------------------------------------
  logic clk_sys, rst, req_valid, req_ready, req_wr, done_q, bit_q;
  logic range_err_q, sfr_en, sfr_wr, code_en;
  msd_op_t req_op;
  msd_space_t space_q;
  logic [7:0] req_addr, acc_in, rd_data_q, power_control_q, ba;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, code_rdata;
  logic [2:0] req_reg, cycles_q;
  logic [1:0] bank_sel, bytes_q;
  logic [15:0] req_data, data_pointer_q, code_addr, last_code;
  logic [7:0] bit_tab [4] = '{8'h00, 8'h7F, 8'h0B, 8'h58};
  int mismatches, n_checks, lat, sfr_hits, pwr_hits, h;

  msd_decoder i_dut (.clk_sys, .rst, .req_valid, .req_ready, .req_op,
    .req_wr, .req_addr, .req_reg, .req_data, .acc_in, .bank_sel, .done_q,
    .rd_data_q, .bit_q, .space_q, .cycles_q, .bytes_q, .range_err_q,
    .data_pointer_q, .power_control_q, .sfr_en, .sfr_wr, .sfr_addr,
    .sfr_wdata, .sfr_rdata, .code_en, .code_addr, .code_rdata);

  msd_far_model i_far (.clk_sys, .sfr_en, .sfr_wr, .sfr_addr, .sfr_wdata,
    .sfr_rdata, .code_en, .code_addr, .code_rdata);

  // Clock
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Count register port strobes and note the flash address
  always @(posedge clk_sys)
  begin
    if (sfr_en === 1'b1)
    begin
      sfr_hits++;
      if (sfr_addr === 8'h87)
        pwr_hits++;
    end
    if (code_en === 1'b1)
      last_code = code_addr;
  end

  // ----------------------------------------------------------
  // Access and compare tasks
  // ----------------------------------------------------------
  function automatic logic [7:0] flash_byte(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5C;
  endfunction : flash_byte

  task automatic chk(input string what, input logic [15:0] exp,
    input logic [15:0] got);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Reported cost and the measured accept-to-done distance
  task automatic chk_cost(input logic [2:0] cyc, input logic [1:0] byt);
    chk("cycles", 16'(cyc), 16'(cycles_q));
    chk("bytes", 16'(byt), 16'(bytes_q));
    chk("latency", 16'(cyc) + 16'h0001, 16'(lat));
  endtask : chk_cost

  // One request, held over the accept edge, then a bounded wait for done
  task automatic run(input msd_op_t op, input logic wr, input logic [7:0] a,
    input logic [2:0] rg, input logic [15:0] d, input logic [7:0] acc);
    req_op = op;
    req_wr = wr;
    req_addr = a;
    req_reg = rg;
    req_data = d;
    acc_in = acc;
    req_valid = 1'b1;
    chk("ready", 16'h0001, 16'(req_ready));
    @(negedge clk_sys);
    req_valid = 1'b0;
    chk("busy", 16'h0000, 16'(req_ready));
    lat = 1;
    while (done_q !== 1'b1 && lat < 20)
    begin
      @(negedge clk_sys);
      lat++;
    end
    chk("done", 16'h0001, 16'(done_q));
  endtask : run

  task automatic dir(input logic wr, input logic [7:0] a,
    input logic [7:0] v);
    run(MSD_OP_DIR, wr, a, 3'h0, 16'h0000, v);
  endtask : dir

  task automatic ptr(input logic [15:0] v);
    run(MSD_OP_DATA_POINTER_IMM, 1'b0, 8'h00, 3'h0, v, 8'h00);
  endtask : ptr

  task automatic xmove(input logic wr, input logic [7:0] v);
    run(MSD_OP_XMOVE_DATA_POINTER, wr, 8'h00, 3'h0, 16'h0000, v);
  endtask : xmove

  task automatic give_verdict();
    if (mismatches == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict

  // Cut a hung run short
  initial
  begin
    #50000;
    mismatches++;
    give_verdict();
  end

  // ----------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------
  initial
  begin
    rst = 1'b1;
    req_valid = 1'b0;
    req_op = MSD_OP_REG;
    req_wr = 1'b0;
    req_addr = 8'h00;
    req_reg = 3'h0;
    req_data = 16'h0000;
    acc_in = 8'h00;
    bank_sel = 2'h0;
    repeat (6) @(negedge clk_sys);
    rst = 1'b0;
    @(negedge clk_sys);
    chk("power_control", 16'h0000, 16'(power_control_q));
    // Register five of every bank, stored directly, read as a register
    for (int b = 0; b < 4; b++)
    begin
      dir(1'b1, 8'(b * 8 + 5), 8'(8'h10 + b));
      bank_sel = 2'(b);
      run(MSD_OP_REG, 1'b0, 8'h00, 3'h5, 16'h0000, 8'h00);
      chk("bank reg", 16'(8'h10 + b), 16'(rd_data_q));
    end
    chk_cost(3'h1, 2'h1);
    run(MSD_OP_IMM, 1'b0, 8'h00, 3'h0, 16'h005A, 8'h00);
    chk("immediate", 16'h005A, 16'(rd_data_q));
    chk("imm space", 16'(MSD_SP_NONE), 16'(space_q));
    chk_cost(3'h2, 2'h2);
    // Lower RAM: direct store, pointer load, indirect read
    dir(1'b1, 8'h45, 8'h6E);
    run(MSD_OP_RI_IMM, 1'b0, 8'h00, 3'h0, 16'h0045, 8'h00);
    h = 16'(cycles_q) * 4 + 16'(bytes_q);
    run(MSD_OP_IND, 1'b0, 8'h00, 3'h0, 16'h0000, 8'h00);
    chk("low ram", 16'h006E, 16'(rd_data_q));
    chk("low space", 16'(MSD_SP_IRAM), 16'(space_q));
    chk("pair cycles", 16'h0004, 16'(h / 4) + 16'(cycles_q));
    chk("pair bytes", 16'h0003, 16'(h % 4) + 16'(bytes_q));
    chk_cost(3'h2, 2'h1);
    // Upper RAM and the register at one address
    run(MSD_OP_RI_IMM, 1'b0, 8'h00, 3'h1, 16'h0082, 8'h00);
    h = sfr_hits;
    run(MSD_OP_IND, 1'b1, 8'h00, 3'h1, 16'h0000, 8'hA5);
    dir(1'b1, 8'h82, 8'h3C);
    run(MSD_OP_IND, 1'b0, 8'h00, 3'h1, 16'h0000, 8'h00);
    chk("upper ram", 16'h00A5, 16'(rd_data_q));
    chk("upper space", 16'(MSD_SP_IRAM), 16'(space_q));
    chk("reg strobes", 16'(h + 1), 16'(sfr_hits));
    dir(1'b0, 8'h82, 8'h00);
    chk("register", 16'h003C, 16'(rd_data_q));
    chk("reg space", 16'(MSD_SP_SFR), 16'(space_q));
    // Power control: byte store, byte read, immune to bit writes
    h = pwr_hits;
    dir(1'b1, 8'h87, 8'h11);
    chk("power_control", 16'h0011, 16'(power_control_q));
    dir(1'b0, 8'h87, 8'h00);
    chk("power read", 16'h0011, 16'(rd_data_q));
    run(MSD_OP_BIT, 1'b1, 8'h87, 3'h0, 16'h0001, 8'h00);
    chk("power_control", 16'h0011, 16'(power_control_q));
    chk("power strobes", 16'(h), 16'(pwr_hits));
    // Bit addresses land on the right byte and bit
    for (int i = 0; i < 4; i++)
    begin
      ba = bit_tab[i];
      dir(1'b1, 8'h20 + 8'(ba[6:3]), 8'h00);
      run(MSD_OP_BIT, 1'b1, ba, 3'h0, 16'h0001, 8'h00);
      dir(1'b0, 8'h20 + 8'(ba[6:3]), 8'h00);
      chk("bit byte", 16'h0001 << ba[2:0], 16'(rd_data_q));
      run(MSD_OP_BIT, 1'b0, ba, 3'h0, 16'h0000, 8'h00);
      chk("bit read", 16'h0001, 16'(bit_q));
    end
    // Extended RAM through the full pointer and through a register
    ptr(16'h0100);
    chk("data_pointer", 16'h0100, data_pointer_q);
    chk_cost(3'h3, 2'h3);
    xmove(1'b1, 8'h77);
    chk_cost(3'h4, 2'h1);
    ptr(16'h0000);
    xmove(1'b1, 8'h12);
    ptr(16'h07FF);
    xmove(1'b1, 8'h3A);
    ptr(16'h0100);
    xmove(1'b0, 8'h00);
    chk("extended", 16'h0077, 16'(rd_data_q));
    chk("ext space", 16'(MSD_SP_EXTENDED_RAM), 16'(space_q));
    ptr(16'h07FF);
    xmove(1'b0, 8'h00);
    chk("ext top", 16'h003A, 16'(rd_data_q));
    chk("ext range", 16'h0000, 16'(range_err_q));
    ptr(16'h0080);
    xmove(1'b1, 8'h4B);
    run(MSD_OP_RI_IMM, 1'b0, 8'h00, 3'h0, 16'h0080, 8'h00);
    run(MSD_OP_XMOVE_RI, 1'b0, 8'h00, 3'h0, 16'h0000, 8'h00);
    chk("ext by reg", 16'h004B, 16'(rd_data_q));
    ptr(16'h0800);
    xmove(1'b0, 8'h00);
    chk("ext beyond", 16'h0001, 16'(range_err_q));
    chk("ext fill", 16'h00FF, 16'(rd_data_q));
    // Flash tables through pointer plus accumulator
    ptr(16'h8002);
    run(MSD_OP_CMOVE, 1'b0, 8'h00, 3'h0, 16'h0000, 8'h00);
    chk("flash", 16'(flash_byte(16'h8002)), 16'(rd_data_q));
    chk("flash addr", 16'h8002, last_code);
    chk("flash space", 16'(MSD_SP_CODE), 16'(space_q));
    chk_cost(3'h4, 2'h1);
    ptr(16'hF7F0);
    run(MSD_OP_CMOVE, 1'b0, 8'h00, 3'h0, 16'h0000, 8'h0F);
    chk("flash top", 16'(flash_byte(16'hF7FF)), 16'(rd_data_q));
    ptr(16'hF800);
    run(MSD_OP_CMOVE, 1'b0, 8'h00, 3'h0, 16'h0000, 8'h00);
    chk("flash beyond", 16'h0001, 16'(range_err_q));
    chk("flash fill", 16'h00FF, 16'(rd_data_q));
    give_verdict();
  end
endmodule : msd_decoder_bench
